// ### shared/sfl_pkg.sv
// Constants, opcodes and types of the serial flash command front end.
// Assumes a 100 MHz core clock; the link clock comes from the host.
package sfl_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_ENABLE_WRITES = 8'h06;
  localparam logic [7:0] OP_DISALLOW_WRITES = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_PAGE_REWRITE = 8'h0A;
  localparam logic [7:0] OP_PAGE_BURN = 8'h02;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'hDB;
  localparam logic [7:0] OP_SUBSECTOR_CLEAR = 8'h20;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;
  localparam logic [7:0] OP_FULL_CLEAR = 8'hC7;
  localparam logic [7:0] OP_LOCK_UPDATE = 8'hE5;
  localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_DEEP = 8'hAB;

  // ****************************************
  // Status byte layout and reset values
  // ****************************************
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_PERMIT_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h1;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int PAGE_BYTES = 256;
  localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int ERASE_TIME_US = 1000;
  localparam int PROGRAM_TIME_US = 1000;
  localparam int PUW_TIME_US = 1000;
  localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYCLES_DEF = PROGRAM_TIME_US * CLK_MHZ;
  localparam int PUW_CYCLES_DEF = PUW_TIME_US * CLK_MHZ;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ERASE_PAGE = 2'h0,
    ERASE_SUBSECTOR = 2'h1,
    ERASE_SECTOR = 2'h2,
    ERASE_FULL = 2'h3
  } sfl_erase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h2,
    ST_SKIP = 3'h3,
    ST_MERGE = 3'h4,
    ST_ERASE = 3'h5,
    ST_PROG = 3'h6
  } sfl_state_t;

endpackage : sfl_pkg

// ### verilog/sfl_sync.sv
// Two-flop level synchroniser, one pair per bit.
// Assumes each input bit is a level that stays put for several clocks.
`timescale 1ns/1ns
module sfl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic stage1;
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          stage1 <= RST_VAL[g];
          q_o[g] <= RST_VAL[g];
        end else begin
          stage1 <= d_i[g];
          q_o[g] <= stage1;
        end
      end
    end
  endgenerate

endmodule : sfl_sync

// ### verilog/sfl_spi_link.sv
// Serial link logic, clocked by the host's serial clock (mode 0 or 3).
// Assumes device select frames every transfer; clock may stop between.
`timescale 1ns/1ns
module sfl_spi_link
  import sfl_pkg::*;
(
  input wire logic sclk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  input wire logic [7:0] status_i,
  output logic [7:0] byte_o,
  output logic byte_tgl_o,
  output logic misaligned_o,
  output logic serial_out_o,
  output logic serial_out_oe_o
);

  logic frame_rst_n;
  logic [2:0] bit_cnt;
  logic [6:0] rx_sr;
  logic first_byte;
  logic fetch;
  logic [7:0] tx_sr;
  logic [7:0] status_sync;
  logic [7:0] rx_byte;
  logic byte_done;

  // Per-frame state clears while deselected or in reset
  assign frame_rst_n = arst_n_i & ~cs_n_i;
  assign rx_byte = {rx_sr, serial_in_i};
  assign byte_done = (bit_cnt == 3'h7);

  sfl_sync #(.W(8), .RST_VAL(STATUS_RESET)) u_stat_sync (
    .clk_i(sclk_i),
    .arst_n_i(arst_n_i),
    .d_i(status_i),
    .q_o(status_sync)
  );

  // ****************************************
  // Rising edge: sample input
  // ****************************************
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 3'h0;
      rx_sr <= 7'h00;
      first_byte <= 1'b1;
      fetch <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sr <= rx_byte[6:0];
      if (byte_done) begin
        first_byte <= 1'b0;
        if (first_byte && rx_byte == OP_STATUS_FETCH) begin
          fetch <= 1'b1;
        end
      end
    end
  end

  // Survive deselect so the core can judge the frame length
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_o <= 8'h00;
      byte_tgl_o <= 1'b0;
      misaligned_o <= 1'b0;
    end else begin
      misaligned_o <= !byte_done;
      if (byte_done) begin
        byte_o <= rx_byte;
        byte_tgl_o <= ~byte_tgl_o;
      end
    end
  end

  // ****************************************
  // Falling edge: present output
  // ****************************************
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_sr <= 8'h00;
    end else if (fetch && bit_cnt == 3'h0) begin
      tx_sr <= status_sync;
    end else begin
      tx_sr <= {tx_sr[6:0], 1'b0};
    end
  end

  assign serial_out_o = tx_sr[7];
  // Released whenever deselected or in reset
  assign serial_out_oe_o = fetch & frame_rst_n;

endmodule : sfl_spi_link

// ### verilog/sfl_flash_core.sv
// Command front end of a paged serial NOR flash, core clock side.
// Assumes a page array with combinational read outside this block;
// the serial link runs on the host's clock inside sfl_spi_link.
//
// Contract
// - Host may use clock mode 0 or mode 3.
// - Input sampled on rising clock, output shifted from falling clock.
// - Serial output released unless the device is selected.
// - One page sequence takes up to 256 bytes within one page.
// - Data bytes fill the buffer from the low address byte onward.
// - Rewrite cycle starts when device select rises.
// - Rewrite merges unwritten bytes from the page, erases, then programs.
// - Programming only clears bits, never sets them.
// - Cycle-active status flag shows a running internal cycle.
// - Deselected device stays active until internal cycles finish.
// - Deep power-down entered by command, left by release command.
// - Deep power-down ignores rewrite, program and erase commands.
// - Status fetch returns the status byte.
// - Modifying commands need a whole number of bytes clocked.
// - Modifying commands need the write-permit latch set.
// - Latch clears on reset and on completion of modifying commands.
// - Hardware reset low freezes and resets the logic.
// - Modifications blocked until the power-up write delay expires.
// - In reset the serial output is released.
`timescale 1ns/1ns
module sfl_flash_core
  import sfl_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEF,
  parameter int PUW_CYCLES = PUW_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic [23:0] arr_addr_o,
  input wire logic [7:0] arr_rdata_i,
  output logic [7:0] arr_wdata_o,
  output logic arr_prog_o,
  output logic arr_erase_o,
  output logic [1:0] arr_erase_kind_o,
  output logic cycle_active_o,
  output logic write_permit_o,
  output logic deep_pd_o,
  output logic pwr_active_o,
  output logic reject_o
);

  // ****************************************
  // Link and crossings
  // ****************************************
  logic [7:0] link_byte;
  logic link_tgl;
  logic link_odd;
  logic [7:0] status;
  logic [2:0] sync_out;
  logic cs_n_s;
  logic tgl_s;
  logic odd_s;
  logic tgl_d;
  logic cs_n_d;
  logic frame_end;
  logic armed;

  sfl_spi_link u_link (
    .sclk_i(sclk_i),
    .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i),
    .serial_in_i(serial_in_i),
    .status_i(status),
    .byte_o(link_byte),
    .byte_tgl_o(link_tgl),
    .misaligned_o(link_odd),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o)
  );

  sfl_sync #(.W(3), .RST_VAL(SYNC_RESET)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({link_odd, link_tgl, cs_n_i}),
    .q_o(sync_out)
  );

  assign cs_n_s = sync_out[0];
  assign tgl_s = sync_out[1];
  assign odd_s = sync_out[2];

  // Byte data is held steady for a whole byte time after its toggle
  wire byte_ev = (tgl_s != tgl_d) && armed && !cs_n_s;
  wire cs_rise = cs_n_s && !cs_n_d;
  wire cs_fall = !cs_n_s && cs_n_d;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_d <= 1'b0;
      cs_n_d <= 1'b1;
      frame_end <= 1'b0;
      armed <= 1'b0;
    end else begin
      tgl_d <= tgl_s;
      cs_n_d <= cs_n_s;
      // One cycle late so a last byte is taken first
      frame_end <= cs_rise && armed;
      if (cs_fall) begin
        armed <= 1'b1;
      end
    end
  end

  // ****************************************
  // Power-up write delay
  // ****************************************
  logic [31:0] puw_cnt;
  wire puw_done = (puw_cnt == 32'h0);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      puw_cnt <= 32'(PUW_CYCLES);
    end else if (!puw_done) begin
      puw_cnt <= puw_cnt - 32'h1;
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  sfl_state_t state;
  sfl_state_t next_state;
  logic [7:0] opcode;
  logic [1:0] hdr_cnt;
  logic [23:0] addr;
  logic [7:0] wr_idx;
  logic got_data;
  logic permit;
  logic deep;
  logic [PAGE_BYTES-1:0] filled;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [31:0] timer;
  logic [7:0] step_idx;
  logic phase;

  wire is_rewrite = (opcode == OP_PAGE_REWRITE);
  wire is_burn = (opcode == OP_PAGE_BURN);
  wire is_page_cmd = is_rewrite || is_burn;
  wire is_lock = (opcode == OP_LOCK_UPDATE);
  wire is_full = (opcode == OP_FULL_CLEAR);
  wire is_erase = (opcode == OP_PAGE_CLEAR) ||
                  (opcode == OP_SUBSECTOR_CLEAR) ||
                  (opcode == OP_SECTOR_CLEAR) || is_full;
  wire is_modify = is_page_cmd || is_erase || is_lock;
  wire needs_addr = is_page_cmd || is_lock || (is_erase && !is_full);

  wire byte_is_op = byte_ev && (state == ST_IDLE);
  wire op_has_addr = (link_byte == OP_PAGE_REWRITE) ||
                     (link_byte == OP_PAGE_BURN) ||
                     (link_byte == OP_LOCK_UPDATE) ||
                     (link_byte == OP_PAGE_CLEAR) ||
                     (link_byte == OP_SUBSECTOR_CLEAR) ||
                     (link_byte == OP_SECTOR_CLEAR);

  wire in_parse = (state == ST_IDLE) || (state == ST_ADDR) ||
                  (state == ST_DATA) || (state == ST_SKIP);
  wire busy = !in_parse;
  wire header_ok = !needs_addr || (state == ST_DATA && (!is_page_cmd ||
                   got_data)) || (state == ST_IDLE && is_full);
  logic got_op;
  wire op_seen = (state != ST_IDLE) || got_op;

  // Frame verdict for a modifying command
  wire mod_frame = frame_end && in_parse && op_seen && is_modify && !deep;
  wire mod_ok = mod_frame && !odd_s && permit && puw_done &&
                header_ok;
  wire mod_rej = mod_frame && !mod_ok;
  wire start_page = mod_ok && is_page_cmd;
  wire start_erase = mod_ok && is_erase;
  wire one_byte = frame_end && in_parse && !odd_s && op_seen &&
                  (state == ST_IDLE || state == ST_SKIP);

  wire [31:0] wait_cycles = (state == ST_ERASE) ? 32'(ERASE_CYCLES) :
                            32'(PROGRAM_CYCLES);
  wire timer_done = (timer == wait_cycles);
  wire step_last = (step_idx == 8'hFF) && phase;
  wire cycle_end = (state == ST_ERASE && timer_done && !is_rewrite) ||
                   (state == ST_PROG && timer_done);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (byte_is_op) begin
          next_state = op_has_addr ? ST_ADDR : ST_SKIP;
        end
      end
      ST_ADDR: begin
        if (byte_ev && hdr_cnt == ADDR_BYTES_LAST) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        next_state = ST_DATA;
      end
      ST_SKIP: begin
        next_state = ST_SKIP;
      end
      ST_MERGE: begin
        if (step_last) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (timer_done) begin
          next_state = is_rewrite ? ST_PROG : ST_IDLE;
        end
      end
      ST_PROG: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (frame_end && in_parse) begin
      if (start_page) begin
        next_state = is_rewrite ? ST_MERGE : ST_PROG;
      end else if (start_erase) begin
        next_state = ST_ERASE;
      end else begin
        next_state = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      got_op <= 1'b0;
    end else begin
      state <= next_state;
      if (frame_end) begin
        got_op <= 1'b0;
      end else if (byte_is_op) begin
        got_op <= 1'b1;
      end
    end
  end

  // ****************************************
  // Header and page buffer
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opcode <= 8'h00;
      hdr_cnt <= 2'h0;
      addr <= 24'h000000;
      wr_idx <= 8'h00;
      got_data <= 1'b0;
    end else if (byte_is_op) begin
      opcode <= link_byte;
      hdr_cnt <= 2'h0;
      got_data <= 1'b0;
    end else if (byte_ev && state == ST_ADDR) begin
      hdr_cnt <= hdr_cnt + 2'h1;
      addr <= {addr[15:0], link_byte};
      wr_idx <= link_byte;
    end else if (byte_ev && state == ST_DATA) begin
      got_data <= 1'b1;
      wr_idx <= wr_idx + 8'h1;
    end
  end

  wire buf_host_wr = byte_ev && state == ST_DATA && is_page_cmd;
  wire buf_merge_wr = (state == ST_MERGE) && phase && !filled[step_idx];

  always_ff @(posedge clk_i) begin
    if (buf_host_wr) begin
      page_buf[wr_idx] <= link_byte;
    end else if (buf_merge_wr) begin
      page_buf[step_idx] <= arr_rdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filled <= '0;
    end else if (byte_is_op) begin
      filled <= '0;
    end else if (buf_host_wr) begin
      filled[wr_idx] <= 1'b1;
    end
  end

  // ****************************************
  // Internal cycles
  // ****************************************
  wire stepping = (state == ST_MERGE) ||
                  (state == ST_PROG && !(step_idx == 8'hFF && phase) &&
                   timer == 32'h0);
  wire prog_now = (state == ST_PROG) && phase && timer == 32'h0;
  wire [7:0] keep_byte = filled[step_idx] || is_rewrite ?
                         page_buf[step_idx] : 8'hFF;
  logic prog_tail;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_idx <= 8'h00;
      phase <= 1'b0;
      timer <= 32'h0;
      prog_tail <= 1'b0;
    end else if (state != next_state) begin
      step_idx <= 8'h00;
      phase <= 1'b0;
      timer <= 32'h0;
      prog_tail <= 1'b0;
    end else if (stepping && !prog_tail) begin
      phase <= ~phase;
      if (phase) begin
        step_idx <= step_idx + 8'h1;
        prog_tail <= (state == ST_PROG) && step_idx == 8'hFF;
      end
    end else if (state == ST_ERASE || state == ST_PROG) begin
      timer <= timer + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arr_addr_o <= 24'h000000;
      arr_wdata_o <= 8'hFF;
      arr_prog_o <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_erase_kind_o <= ERASE_PAGE;
    end else begin
      arr_prog_o <= prog_now && !prog_tail;
      arr_erase_o <= (next_state == ST_ERASE) && (state != ST_ERASE);
      if (state == ST_MERGE || state == ST_PROG) begin
        arr_addr_o <= {addr[23:8], step_idx};
      end else begin
        arr_addr_o <= addr;
      end
      // Only ones may turn to zeros
      arr_wdata_o <= arr_rdata_i & keep_byte;
      case (opcode)
        OP_SUBSECTOR_CLEAR: arr_erase_kind_o <= ERASE_SUBSECTOR;
        OP_SECTOR_CLEAR: arr_erase_kind_o <= ERASE_SECTOR;
        OP_FULL_CLEAR: arr_erase_kind_o <= ERASE_FULL;
        default: arr_erase_kind_o <= ERASE_PAGE;
      endcase
    end
  end

  // ****************************************
  // Latch, power modes, status
  // ****************************************
  wire lock_done = mod_ok && is_lock;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      permit <= 1'b0;
      deep <= 1'b0;
      reject_o <= 1'b0;
    end else begin
      reject_o <= mod_rej;
      if (cycle_end || lock_done) begin
        permit <= 1'b0;
      end else if (one_byte && !deep) begin
        if (opcode == OP_ENABLE_WRITES) begin
          permit <= 1'b1;
        end else if (opcode == OP_DISALLOW_WRITES) begin
          permit <= 1'b0;
        end
      end
      if (one_byte && opcode == OP_DEEP_POWER_DOWN && !busy) begin
        deep <= 1'b1;
      end else if (one_byte && opcode == OP_RELEASE_DEEP) begin
        deep <= 1'b0;
      end
    end
  end

  always_comb begin
    status = STATUS_RESET;
    status[STAT_ACTIVE_BIT] = busy;
    status[STAT_PERMIT_BIT] = permit;
  end

  assign cycle_active_o = busy;
  assign write_permit_o = permit;
  assign deep_pd_o = deep;
  assign pwr_active_o = !cs_n_s || busy;

endmodule : sfl_flash_core

// ### bench/sfl_flash_core_assertions.sv
// Concurrent checks on the core-side ports of the flash front end.
// Bound to sfl_flash_core; core clock domain only.
`timescale 1ns/1ns
module sfl_flash_core_assertions #(
  parameter int ERASE_CYCLES = 20,
  parameter int PROGRAM_CYCLES = 20,
  parameter int PUW_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic serial_out_oe_o,
  input wire logic [7:0] arr_rdata_i,
  input wire logic [7:0] arr_wdata_o,
  input wire logic arr_prog_o,
  input wire logic arr_erase_o,
  input wire logic cycle_active_o,
  input wire logic write_permit_o,
  input wire logic deep_pd_o,
  input wire logic pwr_active_o,
  input wire logic reject_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_oe_rel; cs_n_i [*6] |-> !serial_out_oe_o; endproperty
  a_oe_rel: assert property (p_oe_rel)
    else $error("output driven while deselected");
  property p_start; $rose(cycle_active_o) |-> cs_n_i && write_permit_o;
  endproperty
  a_start: assert property (p_start)
    else $error("cycle start without deselect or permit");
  property p_erase; arr_erase_o |-> cycle_active_o ##1 !arr_erase_o;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase pulse outside cycle");
  property p_clear_only; arr_prog_o |-> (arr_wdata_o & ~arr_rdata_i) == 8'h00;
  endproperty
  a_clear_only: assert property (p_clear_only)
    else $error("program sets a bit");
  property p_pwr; cycle_active_o |-> pwr_active_o; endproperty
  a_pwr: assert property (p_pwr)
    else $error("standby while busy");
  property p_deep; deep_pd_o && !cycle_active_o |=> !cycle_active_o;
  endproperty
  a_deep: assert property (p_deep)
    else $error("cycle started in deep power-down");
  property p_permit; $fell(cycle_active_o) |-> ##[0:2] !write_permit_o;
  endproperty
  a_permit: assert property (p_permit)
    else $error("permit kept after cycle");
  property p_reject; reject_o && !cycle_active_o |=> !cycle_active_o [*4];
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected command started a cycle");
  property p_hold; $rose(cycle_active_o) |-> cycle_active_o [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("busy flag dropped early");
  property p_prog; arr_prog_o |-> cycle_active_o; endproperty
  a_prog: assert property (p_prog)
    else $error("program pulse outside cycle");
endmodule : sfl_flash_core_assertions

bind sfl_flash_core sfl_flash_core_assertions #(
  .ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES),
  .PUW_CYCLES(PUW_CYCLES)
) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
  .serial_out_oe_o(serial_out_oe_o), .arr_rdata_i(arr_rdata_i),
  .arr_wdata_o(arr_wdata_o), .arr_prog_o(arr_prog_o),
  .arr_erase_o(arr_erase_o), .cycle_active_o(cycle_active_o),
  .write_permit_o(write_permit_o), .deep_pd_o(deep_pd_o),
  .pwr_active_o(pwr_active_o), .reject_o(reject_o)
);

// ### bench/sfl_host_model.sv
// Host SPI master model: select, 32 ns serial clock, data.
// Clock stands at the mode's idle level outside frames.
`timescale 1ns/1ns
module sfl_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic cpol = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic sel;
    sclk_o = cpol;
    #7 cs_n_o = 1'b0;
    #40;
  endtask : sel
  task automatic xfer(input logic [7:0] b, input int n,
      output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk_o = 1'b0;
      mosi_o = b[i];
      #16 sclk_o = 1'b1;
      r[i] = miso_oe_i ? miso_i : 1'bz;
      #16;
    end
  endtask : xfer
  task automatic desel;
    sclk_o = cpol;
    #20 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #80;
  endtask : desel
endmodule : sfl_host_model

// ### bench/sfl_flash_core_bench.sv
// Self-checking bench for the flash front end core.
// Host model drives the link; the array reads back a fixed byte.
`timescale 1ns/1ns
module sfl_flash_core_bench;
  import sfl_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b1;
  logic sclk, cs_n, mosi, miso, oe, prog, erase, busy, permit;
  logic deep, pwr, rej;
  logic [7:0] wdata, s;
  logic [1:0] kind, last_kind;
  logic [23:0] addr;
  logic [15:0] last_pg;
  int n_low = 0;
  logic [7:0] ops [4] = '{OP_PAGE_CLEAR, OP_SUBSECTOR_CLEAR,
    OP_SECTOR_CLEAR, OP_FULL_CLEAR};
  int n_errors = 0;
  int check_count = 0;
  int n_rej = 0;
  int n_er = 0;
  int n_pg = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_rej <= n_rej + int'(rej);
    n_er <= n_er + int'(erase);
    n_pg <= n_pg + int'(prog);
    n_low <= n_low + int'(prog && wdata != 8'hF0);
    if (erase) last_kind <= kind;
    if (erase) last_pg <= addr[23:8];
  end
  sfl_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(oe));
  sfl_flash_core #(.ERASE_CYCLES(20), .PROGRAM_CYCLES(20),
    .PUW_CYCLES(200)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_i(mosi), .serial_out_o(miso), .serial_out_oe_o(oe),
    .arr_addr_o(addr), .arr_rdata_i(8'hF0), .arr_wdata_o(wdata),
    .arr_prog_o(prog), .arr_erase_o(erase), .arr_erase_kind_o(kind),
    .cycle_active_o(busy), .write_permit_o(permit), .deep_pd_o(deep),
    .pwr_active_o(pwr), .reject_o(rej));
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    check_count++;
    if (v !== e) begin
      n_errors++;
      $display("mismatch at %0t: %0h not %0h", $time, v, e);
    end
  endtask : check
  task automatic done_t(input int t);
    $display("test %0d done", t);
  endtask : done_t
  task automatic frame(input logic [7:0] op, input int nb, input int xb);
    logic [7:0] r;
    @(negedge clk_i);
    host.sel();
    host.xfer(op, 8, r);
    for (int i = 0; i < nb; i++) host.xfer(8'(3 * i), 8, r);
    if (xb > 0) host.xfer(8'hFF, xb, r);
    host.desel();
  endtask : frame
  task automatic status;
    @(negedge clk_i);
    host.sel();
    host.xfer(OP_STATUS_FETCH, 8, s);
    host.xfer(8'h00, 8, s);
    host.xfer(8'h00, 8, s);
    host.desel();
  endtask : status
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    check(busy, v);
  endtask : wait_busy
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  initial begin
    #2 arst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    check({oe, busy, permit, deep, pwr, rej}, 0);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_PAGE_BURN, 4, 0);
    repeat (4) @(negedge clk_i);
    check(n_rej, 1);
    check(busy, 0);
    done_t(1);
    repeat (200) @(negedge clk_i);
    frame(OP_DISALLOW_WRITES, 0, 0);
    status();
    check(s, 8'h00);
    frame(OP_ENABLE_WRITES, 0, 0);
    status();
    check(s, 8'h02);
    frame(OP_DISALLOW_WRITES, 0, 0);
    check(permit, 0);
    frame(OP_PAGE_REWRITE, 4, 0);
    repeat (4) @(negedge clk_i);
    check(n_rej, 2);
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_PAGE_REWRITE, 5, 4);
    repeat (4) @(negedge clk_i);
    check(n_rej, 3);
    check(busy, 0);
    done_t(2);
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_PAGE_REWRITE, 6, 0);
    wait_busy(1'b1);
    status();
    check(s, 8'h03);
    check(pwr, 1);
    wait_busy(1'b0);
    check(n_er, 1);
    check(n_pg, 256);
    check(n_low, 3);
    check(permit, 0);
    repeat (8) @(negedge clk_i);
    check(pwr, 0);
    done_t(3);
    host.cpol = 1'b1;
    frame(OP_DEEP_POWER_DOWN, 0, 0);
    repeat (4) @(negedge clk_i);
    check(deep, 1);
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_PAGE_CLEAR, 3, 0);
    repeat (20) @(negedge clk_i);
    check(n_er, 1);
    frame(OP_RELEASE_DEEP, 0, 0);
    repeat (4) @(negedge clk_i);
    check(deep, 0);
    for (int i = 0; i < 4; i++) begin
      frame(OP_ENABLE_WRITES, 0, 0);
      frame(ops[i], i < 3 ? 3 : 0, 0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check(last_kind, i);
      check(last_pg, 16'h0003);
      check(permit, 0);
    end
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_LOCK_UPDATE, 4, 0);
    repeat (4) @(negedge clk_i);
    check(permit, 0);
    frame(OP_ENABLE_WRITES, 0, 0);
    frame(OP_PAGE_BURN, 4, 0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(n_pg, 512);
    check(n_er, 5);
    check(n_low, 4);
    done_t(4);
    finish_test();
  end
endmodule : sfl_flash_core_bench
